// >>> flash_host_pkg.sv
// constants and types shared by the flash host controller
package flash_host_pkg;

  // register offsets, byte addresses on the register bus
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_RDATA = 8'h10;
  localparam logic [7:0] REG_CODES = 8'h14;
  localparam logic [7:0] REG_UADDR = 8'h18;

  // status field positions
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_FAIL = 2;
  localparam int ST_VERR = 3;
  localparam int ST_READY = 4;
  localparam int ST_TOSEEN = 5;

  // codes field positions within the codes register
  localparam int CD_UNLOCK1 = 0;
  localparam int CD_UNLOCK2 = 8;
  localparam int CD_RESUME = 16;
  localparam int CD_RESET = 24;

  // reset values of software registers
  localparam logic [31:0] CODES_RST = 32'h0000_0000;
  localparam logic [31:0] UADDR_RST = 32'h0000_0000;

  // fixed command codes on the flash data bus
  localparam logic [7:0] PROG_SETUP_CODE = 8'ha0;
  localparam logic [7:0] SUSPEND_CODE = 8'hb0;

  // operations started by a write to the command register
  typedef logic [2:0] op_t;
  localparam op_t OP_PROGRAM = 3'h0;
  localparam op_t OP_SUSPEND = 3'h1;
  localparam op_t OP_RESUME = 3'h2;
  localparam op_t OP_RESETCMD = 3'h3;
  localparam op_t OP_READ = 3'h4;
  localparam op_t OP_HWRESET = 3'h5;

  // status bit positions on the flash data bus
  localparam int DQ_POLL = 7;
  localparam int DQ_TOGGLE = 6;
  localparam int DQ_TIMEOUT = 5;

  // program sequence steps
  localparam logic [2:0] STEP_TARGET = 3'h3;
  localparam logic [2:0] STEP_POLL1 = 3'h4;
  localparam logic [2:0] STEP_POLL2 = 3'h5;
  localparam logic [2:0] STEP_FINAL = 3'h6;
  localparam logic [2:0] STEP_ABORT = 3'h7;

  // timing
  localparam int CLK_NS = 40;
  localparam int T_WP_NS = 35;
  localparam int T_ACC_NS = 90;
  localparam int T_RP_NS = 500;
  localparam int SYNC_CYC = 2;
  localparam logic [3:0] WR_CYC = 4'((T_WP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] ACC_CYC = 4'((T_ACC_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] RD_CYC = ACC_CYC + 4'(SYNC_CYC) + 4'h1;
  localparam logic [7:0] RP_CYC = 8'((T_RP_NS + CLK_NS - 1) / CLK_NS);

  typedef struct packed {
    logic ce_n;
    logic we_n;
    logic oe_n;
    logic [17:0] addr;
    logic [15:0] dq_out;
    logic dq_oe;
  } flash_pins_s;

  localparam flash_pins_s PINS_IDLE = '{1'b1, 1'b1, 1'b1, 18'h0, 16'h0, 1'b0};

  typedef struct packed {
    logic rd;
    logic [17:0] addr;
    logic [15:0] data;
  } cyc_req_s;

  function automatic cyc_req_s mk_req(input logic rd, input logic [17:0] a,
                                      input logic [15:0] d);
    cyc_req_s r;
    r.rd = rd;
    r.addr = a;
    r.data = d;
    return r;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

endpackage

// >>> flash_cycle.sv
// one flash bus cycle, write or read, with strobe timing
`timescale 1ns/1ps
`default_nettype none
module flash_cycle
  import flash_host_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // request
  input wire logic start_in,
  input wire cyc_req_s req_in,
  output logic done_out,
  output logic [15:0] rdata_out,
  // flash pins
  input wire logic [15:0] dq_in,
  output flash_pins_s pins_out
);

  typedef enum logic [3:0] {
    C_IDLE = 4'b0001,
    C_SETUP = 4'b0010,
    C_PULSE = 4'b0100,
    C_HOLD = 4'b1000
  } cyc_e;

  typedef struct packed {
    cyc_e ph;
    logic [3:0] cnt;
    logic rd;
    logic done;
    logic [15:0] rdata;
    logic [15:0] s1;
    logic [15:0] s2;
    flash_pins_s pins;
  } cyc_state_s;

  localparam cyc_state_s RST = '{C_IDLE, 4'h0, 1'b0, 1'b0, 16'h0, 16'h0,
                                 16'h0, PINS_IDLE};

  cyc_state_s q;
  cyc_state_s n;

  always_comb begin
    n = q;
    n.done = 1'b0;
    n.s1 = dq_in;
    n.s2 = q.s1;
    case (q.ph)
      C_IDLE: begin
        if (start_in) begin
          n.ph = C_SETUP;
          n.rd = req_in.rd;
          n.pins.ce_n = 1'b0;
          n.pins.addr = req_in.addr;
          n.pins.dq_out = req_in.data;
          n.pins.dq_oe = !req_in.rd;
        end
      end
      C_SETUP: begin
        // write strobe falls after chip select
        n.ph = C_PULSE;
        n.cnt = q.rd ? RD_CYC : WR_CYC;
        n.pins.we_n = q.rd;
        n.pins.oe_n = !q.rd;
      end
      C_PULSE: begin
        if (q.cnt == 4'h1) begin
          // write strobe rises first, data still held
          n.ph = C_HOLD;
          n.pins.we_n = 1'b1;
          n.pins.oe_n = 1'b1;
          // sampled late enough to cover access and sync delay
          if (q.rd) begin
            n.rdata = q.s2;
          end
        end else begin
          n.cnt = q.cnt - 4'h1;
        end
      end
      C_HOLD: begin
        n.ph = C_IDLE;
        n.pins.ce_n = 1'b1;
        n.pins.dq_oe = 1'b0;
        n.done = 1'b1;
      end
      default: begin
        n = RST;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      q <= RST;
    end else begin
      q <= n;
    end
  end

  assign done_out = q.done;
  assign rdata_out = q.rdata;
  assign pins_out = q.pins;

endmodule
`default_nettype wire

// >>> flash_host.sv
// host controller driving a parallel flash through its pins
//
// Local design decisions: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module flash_host
  import flash_host_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic arst_n_in,
  // register bus write address
  input wire logic [7:0] awaddr_in,
  input wire logic awvalid_in,
  output logic awready_out,
  // register bus write data
  input wire logic [31:0] wdata_in,
  input wire logic [3:0] wstrb_in,
  input wire logic wvalid_in,
  output logic wready_out,
  // register bus write response
  output logic [1:0] bresp_out,
  output logic bvalid_out,
  input wire logic bready_in,
  // register bus read
  input wire logic [7:0] araddr_in,
  input wire logic arvalid_in,
  output logic arready_out,
  output logic [31:0] rdata_out,
  output logic [1:0] rresp_out,
  output logic rvalid_out,
  input wire logic rready_in,
  // flash pins
  output logic flash_ce_n_out,
  output logic flash_we_n_out,
  output logic flash_oe_n_out,
  output logic flash_reset_n_out,
  output logic [17:0] flash_addr_out,
  input wire logic [15:0] flash_dq_in,
  output logic [15:0] flash_dq_out,
  output logic flash_dq_oe_out,
  input wire logic ready_busy_n_in
);

  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_CYC = 3'b010,
    S_HWRST = 3'b100
  } seq_e;

  typedef struct packed {
    seq_e st;
    op_t op;
    logic [2:0] step;
    logic [17:0] addr;
    logic [15:0] wdata;
    logic [31:0] codes;
    logic [31:0] uaddr;
    logic [15:0] rdata;
    logic [15:0] poll1;
    logic to_seen;
    logic done;
    logic fail;
    logic verr;
    logic rb1;
    logic rb2;
    logic [7:0] rst_cnt;
    logic flash_rst_n;
    logic cyc_start;
    cyc_req_s req;
    logic aw_h;
    logic w_h;
    logic [7:0] awa;
    logic [31:0] wd;
    logic [3:0] ws;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rd;
    logic [1:0] rresp;
  } host_state_s;

  localparam host_state_s RST = '{
    S_IDLE, OP_READ, 3'h0, 18'h0, 16'h0, CODES_RST, UADDR_RST, 16'h0,
    16'h0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 8'h0, 1'b1, 1'b0,
    '0, 1'b0, 1'b0, 8'h0, 32'h0, 4'h0, 1'b0, 2'b00, 1'b0, 32'h0, 2'b00};

  logic [1:0] rsync_q;
  logic rst_n;
  host_state_s q;
  host_state_s n;
  logic cyc_done;
  logic [15:0] cyc_rdata;
  flash_pins_s pins;

  // release is synchronous so every flop leaves reset together
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rsync_q <= 2'b00;
    end else begin
      rsync_q <= {rsync_q[0], 1'b1};
    end
  end
  assign rst_n = rsync_q[1];

  flash_cycle u_cycle (
    .clk_in(clk_in),
    .rst_n_in(rst_n),
    .start_in(q.cyc_start),
    .req_in(q.req),
    .done_out(cyc_done),
    .rdata_out(cyc_rdata),
    .dq_in(flash_dq_in),
    .pins_out(pins)
  );

  always_comb begin
    logic [15:0] r;
    logic [17:0] ua1;
    logic [17:0] ua2;
    r = cyc_rdata;
    ua1 = {2'b00, q.uaddr[15:0]};
    ua2 = {2'b00, q.uaddr[31:16]};
    n = q;
    n.cyc_start = 1'b0;
    // busy pin passes two flops before use
    n.rb1 = ready_busy_n_in;
    n.rb2 = q.rb1;

    case (q.st)
      S_IDLE: begin
      end
      S_CYC: begin
        if (cyc_done) begin
          if (q.op != OP_PROGRAM) begin
            n.st = S_IDLE;
            n.done = 1'b1;
            if (q.op == OP_READ) begin
              n.rdata = r;
            end
          end else begin
            n.cyc_start = 1'b1;
            case (q.step)
              3'h0: begin
                n.req = mk_req(1'b0, ua2,
                               {8'h00, q.codes[CD_UNLOCK2 +: 8]});
                n.step = 3'h1;
              end
              3'h1: begin
                n.req = mk_req(1'b0, ua1, {8'h00, PROG_SETUP_CODE});
                n.step = 3'h2;
              end
              3'h2: begin
                n.req = mk_req(1'b0, q.addr, q.wdata);
                n.step = STEP_TARGET;
              end
              STEP_TARGET: begin
                // status is read at the program address
                n.req = mk_req(1'b1, q.addr, 16'h0);
                n.step = STEP_POLL1;
              end
              STEP_POLL1: begin
                n.poll1 = r;
                n.req = mk_req(1'b1, q.addr, 16'h0);
                n.step = STEP_POLL2;
              end
              STEP_POLL2: begin
                // toggle steady over two reads ends polling
                if (r[DQ_TOGGLE] == q.poll1[DQ_TOGGLE]) begin
                  // data taken from a further read
                  n.req = mk_req(1'b1, q.addr, 16'h0);
                  n.step = STEP_FINAL;
                end else if (q.to_seen) begin
                  // still toggling after timeout: reset command
                  n.req = mk_req(1'b0, q.addr,
                                 {8'h00, q.codes[CD_RESET +: 8]});
                  n.step = STEP_ABORT;
                end else begin
                  // still toggling, no timeout yet: note timeout bit, read again
                  n.to_seen = r[DQ_TIMEOUT];
                  n.poll1 = r;
                  n.req = mk_req(1'b1, q.addr, 16'h0);
                end
              end
              STEP_FINAL: begin
                n.cyc_start = 1'b0;
                n.st = S_IDLE;
                n.done = 1'b1;
                n.rdata = r;
                // a one over a stored zero reads back wrong
                n.verr = (r != q.wdata);
              end
              default: begin
                n.cyc_start = 1'b0;
                n.st = S_IDLE;
                n.done = 1'b1;
                n.fail = 1'b1;
              end
            endcase
          end
        end
      end
      S_HWRST: begin
        // reset pin held low for the minimum pulse
        if (q.rst_cnt == 8'h1) begin
          n.flash_rst_n = 1'b1;
          n.st = S_IDLE;
          n.done = 1'b1;
        end else begin
          n.rst_cnt = q.rst_cnt - 8'h1;
        end
      end
      default: begin
        n.st = S_IDLE;
      end
    endcase

    // register bus write path
    if (awvalid_in && !q.aw_h && !q.bvalid) begin
      n.aw_h = 1'b1;
      n.awa = awaddr_in;
    end
    if (wvalid_in && !q.w_h && !q.bvalid) begin
      n.w_h = 1'b1;
      n.wd = wdata_in;
      n.ws = wstrb_in;
    end
    if (q.bvalid && bready_in) begin
      n.bvalid = 1'b0;
    end
    if (q.aw_h && q.w_h) begin
      n.aw_h = 1'b0;
      n.w_h = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = 2'b00;
      case (q.awa)
        REG_CMD: begin
          // no new command while an operation runs
          if (q.ws[0] && q.st == S_IDLE) begin
            n.op = q.wd[2:0];
            n.done = 1'b0;
            n.fail = 1'b0;
            n.verr = 1'b0;
            n.to_seen = 1'b0;
            n.step = 3'h0;
            n.st = S_CYC;
            n.cyc_start = 1'b1;
            case (q.wd[2:0])
              // first unlock write opens the program sequence
              OP_PROGRAM: n.req = mk_req(1'b0, ua1,
                                        {8'h00, q.codes[CD_UNLOCK1 +: 8]});
              // suspend code on the data bus
              OP_SUSPEND: n.req = mk_req(1'b0, q.addr,
                                        {8'h00, SUSPEND_CODE});
              OP_RESUME: n.req = mk_req(1'b0, q.addr,
                                       {8'h00, q.codes[CD_RESUME +: 8]});
              OP_RESETCMD: n.req = mk_req(1'b0, q.addr,
                                         {8'h00, q.codes[CD_RESET +: 8]});
              OP_READ: n.req = mk_req(1'b1, q.addr, 16'h0);
              OP_HWRESET: begin
                n.cyc_start = 1'b0;
                n.st = S_HWRST;
                n.flash_rst_n = 1'b0;
                n.rst_cnt = RP_CYC;
              end
              default: begin
                n.cyc_start = 1'b0;
                n.st = S_IDLE;
                n.bresp = 2'b10;
              end
            endcase
          end
        end
        REG_ADDR: n.addr = 18'(merge({14'h0, q.addr}, q.wd, q.ws));
        REG_WDATA: n.wdata = 16'(merge({16'h0, q.wdata}, q.wd, q.ws));
        REG_CODES: n.codes = merge(q.codes, q.wd, q.ws);
        REG_UADDR: n.uaddr = merge(q.uaddr, q.wd, q.ws);
        REG_STATUS, REG_RDATA: begin
        end
        default: n.bresp = 2'b10;
      endcase
    end

    // register bus read path
    if (q.rvalid && rready_in) begin
      n.rvalid = 1'b0;
    end
    if (arvalid_in && !q.rvalid) begin
      n.rvalid = 1'b1;
      n.rresp = 2'b00;
      n.rd = 32'h0;
      case (araddr_in)
        REG_CMD: n.rd = {29'h0, q.op};
        REG_ADDR: n.rd = {14'h0, q.addr};
        REG_WDATA: n.rd = {16'h0, q.wdata};
        REG_STATUS: begin
          n.rd[ST_BUSY] = (q.st != S_IDLE);
          n.rd[ST_DONE] = q.done;
          n.rd[ST_FAIL] = q.fail;
          n.rd[ST_VERR] = q.verr;
          n.rd[ST_READY] = q.rb2;
          n.rd[ST_TOSEEN] = q.to_seen;
        end
        REG_RDATA: n.rd = {16'h0, q.rdata};
        REG_CODES: n.rd = q.codes;
        REG_UADDR: n.rd = q.uaddr;
        default: n.rresp = 2'b10;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      q <= RST;
    end else begin
      q <= n;
    end
  end

  // no handshake while the internal reset is still held
  assign awready_out = rst_n && !q.aw_h && !q.bvalid;
  assign wready_out = rst_n && !q.w_h && !q.bvalid;
  assign bvalid_out = q.bvalid;
  assign bresp_out = q.bresp;
  assign arready_out = rst_n && !q.rvalid;
  assign rvalid_out = q.rvalid;
  assign rdata_out = q.rd;
  assign rresp_out = q.rresp;
  assign flash_ce_n_out = pins.ce_n;
  assign flash_we_n_out = pins.we_n;
  assign flash_oe_n_out = pins.oe_n;
  assign flash_addr_out = pins.addr;
  assign flash_dq_out = pins.dq_out;
  assign flash_dq_oe_out = pins.dq_oe;
  assign flash_reset_n_out = q.flash_rst_n;

endmodule
`default_nettype wire

// >>> flash_host_assertions.sv
// port-level checks for the flash host controller
`timescale 1ns/1ps
`default_nettype none
module flash_host_assertions (
  // clock and reset
  input wire logic clk_in,
  input wire logic arst_n_in,
  // register bus answers
  input wire logic bvalid_out,
  input wire logic bready_in,
  input wire logic rvalid_out,
  input wire logic rready_in,
  // flash pins
  input wire logic flash_ce_n_out,
  input wire logic flash_we_n_out,
  input wire logic flash_oe_n_out,
  input wire logic flash_reset_n_out,
  input wire logic [17:0] flash_addr_out,
  input wire logic [15:0] flash_dq_out,
  input wire logic flash_dq_oe_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);

  ce_covers_we_a: assert property (!flash_we_n_out |->
    !flash_ce_n_out && flash_dq_oe_out) else $error("we low without ce");
  no_oe_we_a: assert property (flash_oe_n_out || flash_we_n_out)
    else $error("oe and we low together");
  we_pulse_a: assert property ($fell(flash_we_n_out) |=>
    flash_we_n_out) else $error("write pulse not one cycle");
  data_at_rise_a: assert property ($rose(flash_we_n_out) |->
    !flash_ce_n_out && $stable(flash_dq_out) ##1 flash_ce_n_out)
    else $error("data moved at write rise");
  ce_gap_a: assert property ($rose(flash_ce_n_out) |=> flash_ce_n_out)
    else $error("no idle cycle between flash cycles");
  addr_hold_a: assert property (!flash_ce_n_out &&
    $past(!flash_ce_n_out) |-> $stable(flash_addr_out))
    else $error("address moved inside a cycle");
  read_len_a: assert property ($fell(flash_oe_n_out) |->
    !flash_dq_oe_out throughout (!flash_oe_n_out [*6] ##1 flash_oe_n_out))
    else $error("read strobe length or drive wrong");
  reset_pulse_a: assert property ($fell(flash_reset_n_out) |->
    !flash_reset_n_out [*8]) else $error("reset pulse too short");
  b_once_a: assert property (bvalid_out && bready_in |=> !bvalid_out)
    else $error("write response repeated");
  r_once_a: assert property (rvalid_out && rready_in |=> !rvalid_out)
    else $error("read answer repeated");
endmodule
`default_nettype wire

// >>> flash_dev.sv
// behavioural flash device seen from the host pins
`timescale 1ns/1ps
`default_nettype none
module flash_dev
  import flash_host_pkg::*;
#(
  parameter logic [17:0] UA1 = 18'h00555,
  parameter logic [17:0] UA2 = 18'h002aa,
  parameter logic [7:0] C1 = 8'haa,
  parameter logic [7:0] C2 = 8'h55,
  parameter logic [7:0] CRES = 8'h30,
  parameter logic [7:0] CRST = 8'hf0,
  parameter int BUSY_READS = 3,
  // word index that is write protected
  parameter logic [3:0] PROT = 4'hf
) (
  // strobes and bus
  input wire logic ce_n_in,
  input wire logic we_n_in,
  input wire logic oe_n_in,
  input wire logic reset_n_in,
  input wire logic [17:0] addr_in,
  input wire logic [15:0] dq_in,
  // scenario controls
  input wire logic erase_in,
  input wire logic fail_in,
  // answers
  output logic [15:0] dq_out,
  output logic ready_busy_n_out
);
  logic [15:0] mem [16];
  logic [15:0] pd, last_q, val;
  logic [17:0] la;
  logic [1:0] step;
  logic busy, tgl, tmo, susp, erase_act, wr;
  int left;
  assign wr = !ce_n_in && !we_n_in;
  assign erase_act = erase_in && !susp;
  initial begin
    {pd, last_q, la, step, busy, tgl, tmo, susp, left} = '0;
    foreach (mem[i]) mem[i] = 16'hffff;
  end
  always @(posedge wr) la = addr_in;
  always @(negedge wr) begin
    if (reset_n_in === 1'b1) begin
      if (tmo) begin
        if (dq_in[7:0] == CRST) {busy, tmo} = 2'b00;
      end else if (busy) begin
      end else if (step == 2'h3) begin
        // target data is never a command, whatever its value
        // protected word keeps old data
        if (la[3:0] != PROT) mem[la[3:0]] = mem[la[3:0]] & dq_in;
        pd = dq_in;
        busy = 1'b1;
        tmo = fail_in;
        left = BUSY_READS;
        step = 2'h0;
      end else if (dq_in[7:0] == CRST) step = 2'h0;
      else if (step == 2'h0 && dq_in[7:0] == SUSPEND_CODE) begin
        if (erase_act) susp = 1'b1;
      end else if (step == 2'h0 && dq_in[7:0] == CRES) susp = 1'b0;
      else if (step == 2'h0 && la == UA1 && dq_in[7:0] == C1) step = 2'h1;
      else if (step == 2'h1 && la == UA2 && dq_in[7:0] == C2) step = 2'h2;
      else if (step == 2'h2 && dq_in[7:0] == PROG_SETUP_CODE) step = 2'h3;
      else step = 2'h0;
    end
  end
  always @(negedge reset_n_in) {busy, tmo, step} = '0;
  // status word while busy or erasing
  assign val = busy ? {8'h00, ~pd[7], tgl, tmo, 5'h00} :
    erase_act ? {9'h000, tgl, 6'h00} : mem[addr_in[3:0]];
  // released bus shows the inverse of the last word
  assign dq_out = (!ce_n_in && !oe_n_in) ? val : ~last_q;
  // toggle per read, done after the set count
  always @(posedge oe_n_in) begin
    if (ce_n_in === 1'b0) begin
      last_q = val;
      if (busy || erase_act) tgl = !tgl;
      if (busy && !tmo) begin
        left--;
        if (left == 0) busy = 1'b0;
      end
    end
  end
  // busy low while programming or erasing
  assign ready_busy_n_out = !(busy || erase_act);
endmodule
`default_nettype wire

// >>> flash_host_tb.sv
// self-checking bench for the flash host controller
`timescale 1ns/1ps
`default_nettype none
module flash_host_tb import flash_host_pkg::*;;
  logic clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic [7:0] awaddr = '0, araddr = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  logic [31:0] wdata = '0, rdata, rnd = 32'hb237;
  logic erase_m = 1'b0, fail_m = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, rb_n, ce_n, we_n, oe_n;
  logic rst_n, dq_oe;
  logic [1:0] bresp, rresp;
  logic [17:0] fa;
  logic [15:0] fdq, dev_dq, bus;
  logic [15:0] em [16];
  int n_errors = 0, n_checks = 0, cyc = 0;

  always #20 clk_in = ~clk_in;
  assign bus = dq_oe ? fdq : dev_dq;

  flash_host i_dut (.clk_in(clk_in), .arst_n_in(arst_n_in),
    .awaddr_in(awaddr), .awvalid_in(awvalid), .awready_out(awready),
    .wdata_in(wdata), .wstrb_in(4'hf), .wvalid_in(wvalid),
    .wready_out(wready), .bresp_out(bresp), .bvalid_out(bvalid),
    .bready_in(1'b1), .araddr_in(araddr), .arvalid_in(arvalid),
    .arready_out(arready), .rdata_out(rdata), .rresp_out(rresp),
    .rvalid_out(rvalid), .rready_in(1'b1), .flash_ce_n_out(ce_n),
    .flash_we_n_out(we_n), .flash_oe_n_out(oe_n),
    .flash_reset_n_out(rst_n), .flash_addr_out(fa), .flash_dq_in(bus),
    .flash_dq_out(fdq), .flash_dq_oe_out(dq_oe), .ready_busy_n_in(rb_n));
  flash_dev u_dev (.ce_n_in(ce_n), .we_n_in(we_n), .oe_n_in(oe_n),
    .reset_n_in(rst_n), .addr_in(fa), .dq_in(bus), .erase_in(erase_m),
    .fail_in(fail_m), .dq_out(dev_dq), .ready_busy_n_out(rb_n));

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic end_sim();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge clk_in);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge clk_in);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
  endtask

  // issue an operation and wait for the controller to go idle
  task automatic cmd(input op_t op, output logic [31:0] v);
    logic [1:0] r;
    wr(REG_CMD, {29'h0, op}, r);
    for (int k = 0; k < 400; k++) begin
      rd(REG_STATUS, v, r);
      if (v[ST_BUSY] === 1'b0) break;
    end
    chk("idle", 32'h0, 32'(v[ST_BUSY]));
  endtask

  task automatic prog(input logic [17:0] a, input logic [15:0] d,
                      input logic fl);
    logic [31:0] v;
    logic [1:0] r;
    wr(REG_ADDR, {14'h0, a}, r);
    wr(REG_WDATA, {16'h0, d}, r);
    if (a[3:0] != 4'hf) em[a[3:0]] = em[a[3:0]] & d;
    cmd(OP_PROGRAM, v);
    chk("fail", 32'(fl), 32'(v[ST_FAIL]));
    if (fl) begin
      chk("toseen", 32'h1, 32'(v[ST_TOSEEN]));
      chk("dev_busy", 32'h0, 32'(u_dev.busy));
    end else begin
      chk("verr", 32'(em[a[3:0]] != d), 32'(v[ST_VERR]));
      rd(REG_RDATA, v, r);
      chk("rdata", {16'h0, em[a[3:0]]}, v);
      cmd(OP_READ, v);
      rd(REG_RDATA, v, r);
      chk("read", {16'h0, em[a[3:0]]}, v);
    end
  endtask

  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_errors++;
      end_sim();
    end
  end

  initial begin
    logic [31:0] v;
    logic [1:0] r;
    foreach (em[i]) em[i] = 16'hffff;
    repeat (12) @(posedge clk_in);
    arst_n_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    rd(REG_CODES, v, r);
    chk("codes_rst", CODES_RST, v);
    rd(REG_UADDR, v, r);
    chk("uaddr_rst", UADDR_RST, v);
    wr(REG_CODES, 32'hf03055aa, r);
    wr(REG_UADDR, 32'h02aa0555, r);
    rd(REG_CODES, v, r);
    chk("codes", 32'hf03055aa, v);
    wr(8'h40, 32'h1, r);
    chk("wr_unmapped", 32'h2, 32'(r));
    rd(8'h40, v, r);
    chk("rd_unmapped", 32'h2, 32'(r));
    wr(REG_CMD, 32'h6, r);
    chk("bad_op", 32'h2, 32'(r));
    $display("test registers done");
    prog(18'h00003, 16'h0000, 1'b0);
    prog(18'h00003, 16'hffff, 1'b0);
    prog(18'h0000f, 16'h00a5, 1'b0);
    for (int i = 0; i < 6; i++) begin
      rnd = lfsr(rnd);
      prog(rnd[17:0], rnd[31:16], 1'b0);
    end
    $display("test program done");
    erase_m <= 1'b1;
    repeat (4) @(posedge clk_in);
    rd(REG_STATUS, v, r);
    chk("rb_erase", 32'h0, 32'(v[ST_READY]));
    cmd(OP_SUSPEND, v);
    chk("susp", 32'h1, 32'(u_dev.susp));
    rd(REG_STATUS, v, r);
    chk("rb_susp", 32'h1, 32'(v[ST_READY]));
    prog(18'h00009, 16'h5a5a, 1'b0);
    cmd(OP_RESUME, v);
    chk("resume", 32'h0, 32'(u_dev.susp));
    cmd(OP_SUSPEND, v);
    chk("resusp", 32'h1, 32'(u_dev.susp));
    cmd(OP_RESUME, v);
    erase_m <= 1'b0;
    cmd(OP_SUSPEND, v);
    chk("susp_idle", 32'h0, 32'(u_dev.susp));
    $display("test suspend done");
    fail_m <= 1'b1;
    prog(18'h0000c, 16'h00ff, 1'b1);
    fail_m <= 1'b0;
    cmd(OP_RESETCMD, v);
    chk("rstcmd_done", 32'h1, 32'(v[ST_DONE]));
    $display("test timeout done");
    cmd(OP_HWRESET, v);
    chk("hw_reset", 32'h0, 32'(u_dev.busy));
    prog(18'h0000e, 16'h1234, 1'b0);
    $display("test reset done");
    end_sim();
  end
endmodule

bind flash_host flash_host_assertions u_chk (.clk_in(clk_in),
  .arst_n_in(arst_n_in), .bvalid_out(bvalid_out), .bready_in(bready_in),
  .rvalid_out(rvalid_out), .rready_in(rready_in),
  .flash_ce_n_out(flash_ce_n_out), .flash_we_n_out(flash_we_n_out),
  .flash_oe_n_out(flash_oe_n_out), .flash_reset_n_out(flash_reset_n_out),
  .flash_addr_out(flash_addr_out), .flash_dq_out(flash_dq_out),
  .flash_dq_oe_out(flash_dq_oe_out));
`default_nettype wire
